// [design/pad_ctrl_pkg.sv]
// constants, layouts and types shared by the pad control block
// Operation
// - per-pad pull direction, documented pads default up/down
// - per-pad pull enable, only four pads enabled
// - filter control only on reset and nmi pads
// - filter enabled at reset only on reset pad
// - open drain only for i2c or uart transmit
// - open drain disabled on every pad at reset
// - high drive only on listed port b/d/e pads
// - high drive cleared on every pad at reset
// - every port: interrupt, dma request, lock bit
// - nmi pad driven low forces nmi request while its mux is alt seven
// - safety input polarity programmable, default active low
package pad_ctrl_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int PORT_COUNT    = 5;
  localparam int PADS_PER_PORT = 18;
  localparam int PAD_COUNT     = PORT_COUNT * PADS_PER_PORT;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;
  localparam int MUX_W         = 3;

  // pad indices: port * 18 + pin
  localparam int DEBUG_DATA_PAD  = 4;
  localparam int RESET_PAD       = 5;
  localparam int DEBUG_CLOCK_PAD = 40;
  localparam int NMI_PAD         = 57;
  localparam int HD_B4 = 22;
  localparam int HD_B5 = 23;
  localparam int HD_D0 = 54;
  localparam int HD_D1 = 55;
  localparam int HD_D15 = 69;
  localparam int HD_D16 = 70;
  localparam int HD_E0 = 72;
  localparam int HD_E1 = 73;
  localparam int ABSENT_PAD = 89;

  localparam logic [PAD_COUNT-1:0] ONE = {{(PAD_COUNT-1){1'b0}}, 1'b1};
  localparam logic [PAD_COUNT-1:0] PAD_EXISTS = ~(ONE << ABSENT_PAD);
  localparam logic [PAD_COUNT-1:0] PULL_SEL_DEF = (ONE << DEBUG_DATA_PAD) | (ONE << RESET_PAD) | (ONE << NMI_PAD);
  localparam logic [PAD_COUNT-1:0] PULL_EN_DEF  = PULL_SEL_DEF | (ONE << DEBUG_CLOCK_PAD);
  localparam logic [PAD_COUNT-1:0] MUX7_DEF     = PULL_EN_DEF;
  localparam logic [PAD_COUNT-1:0] FILT_CAP     = (ONE << RESET_PAD) | (ONE << NMI_PAD);
  localparam logic [PAD_COUNT-1:0] FILT_DEF     = ONE << RESET_PAD;
  localparam logic [PAD_COUNT-1:0] HD_CAP = (ONE << HD_B4) | (ONE << HD_B5) | (ONE << HD_D0) | (ONE << HD_D1)
                                          | (ONE << HD_D15) | (ONE << HD_D16) | (ONE << HD_E0) | (ONE << HD_E1);

  localparam logic [MUX_W-1:0] MUX_ALT_ZERO  = 3'h0;
  localparam logic [MUX_W-1:0] MUX_ALT_SEVEN = 3'h7;

  // ****************************************
  // register map (word index)
  // ****************************************
  localparam logic [ADDR_W-1:0] PAD_LIMIT      = 8'h5a;
  localparam logic [ADDR_W-1:0] STATUS_ADDR    = 8'h60;
  localparam logic [ADDR_W-1:0] MASK_ADDR      = 8'h61;
  localparam logic [ADDR_W-1:0] WDOG_CTRL_ADDR = 8'h62;

  // pad register fields
  localparam int F_PULL_SEL = 0;
  localparam int F_PULL_EN  = 1;
  localparam int F_FILT     = 2;
  localparam int F_OD       = 3;
  localparam int F_HD       = 4;
  localparam int F_MUX      = 8;
  localparam int F_LOCK     = 15;
  localparam int F_TRIG     = 16;
  localparam int F_DMA      = 18;
  localparam int F_FLAG     = 24;

  // status and mask fields
  localparam int ST_NMI  = 0;
  localparam int ST_WDOG = 1;
  localparam int ST_PORT = 2;
  localparam int ST_W    = ST_PORT + PORT_COUNT;

  // watchdog monitor control field
  localparam int F_ASSERT_POL = 0;
  localparam logic POL_RST = 1'b0;

  localparam logic [1:0] TRIG_OFF  = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_BOTH = 2'h3;

  typedef struct packed {
    logic [MUX_W-1:0] mux;
    logic             high_drive;
    logic             open_drain;
    logic             filter_en;
    logic             pull_en;
    logic             pull_sel;
  } pad_ctrl_s;

endpackage

// [design/event_flag.sv]
// sticky event flag, write one to clear, set wins
`timescale 1ns/1ps
module event_flag (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // set and clear
  input  wire logic set,
  input  wire logic clr,
  // state
  output logic      q
);

  logic q_reg;
  logic q_next;

  // set beats a clear in the same cycle
  assign q_next = set | (q_reg & ~clr);
  assign q      = q_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

endmodule

// [design/pad_ctrl_cell.sv]
// configuration, lock and pin event logic of one pad
`timescale 1ns/1ps
module pad_ctrl_cell
  import pad_ctrl_pkg::*;
#(
  parameter bit               EXISTS       = 1'b1,
  parameter bit               PULL_SEL_RST = 1'b0,
  parameter bit               PULL_EN_RST  = 1'b0,
  parameter bit               FILT_CAP_P   = 1'b0,
  parameter bit               FILT_RST     = 1'b0,
  parameter bit               HD_CAP_P     = 1'b0,
  parameter logic [MUX_W-1:0] MUX_RST      = MUX_ALT_ZERO
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // register access
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata,
  // pad side
  input  wire logic              pin,
  input  wire logic              od_func,
  output pad_ctrl_s              cfg,
  output logic                   irq_req,
  output logic                   dma_req
);

  localparam pad_ctrl_s RST = '{mux: MUX_RST, high_drive: 1'b0, open_drain: 1'b0,
                                filter_en: FILT_RST, pull_en: PULL_EN_RST, pull_sel: PULL_SEL_RST};

  pad_ctrl_s  cfg_reg;
  pad_ctrl_s  cfg_next;
  logic       lock_reg;
  logic       lock_next;
  logic [1:0] trig_reg;
  logic [1:0] trig_next;
  logic       dma_reg;
  logic       dma_next;
  logic       flag_reg;
  logic       flag_next;
  logic       pin_reg;
  logic       wr_cfg;
  logic       hit;

  // lock freezes everything but the flag clear until reset
  assign wr_cfg = wr_en & EXISTS & ~lock_reg;
  assign cfg_next = wr_cfg ? pad_ctrl_s'{mux: wdata[F_MUX +: MUX_W],
                               high_drive: wdata[F_HD] & HD_CAP_P,
                               open_drain: wdata[F_OD],
                               filter_en:  wdata[F_FILT] & FILT_CAP_P,
                               pull_en:    wdata[F_PULL_EN],
                               pull_sel:   wdata[F_PULL_SEL]}
                           : cfg_reg;
  assign lock_next = lock_reg | (wr_cfg & wdata[F_LOCK]);
  assign trig_next = wr_cfg ? wdata[F_TRIG +: 2] : trig_reg;
  assign dma_next  = wr_cfg ? wdata[F_DMA] : dma_reg;

  assign hit = EXISTS & (((trig_reg == TRIG_RISE) | (trig_reg == TRIG_BOTH)) & pin & ~pin_reg
                       | ((trig_reg == TRIG_FALL) | (trig_reg == TRIG_BOTH)) & ~pin & pin_reg);
  assign flag_next = hit | (flag_reg & ~(wr_en & wdata[F_FLAG]));

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_reg  <= RST;
      lock_reg <= 1'b0;
      trig_reg <= TRIG_OFF;
      dma_reg  <= 1'b0;
      flag_reg <= 1'b0;
      pin_reg  <= 1'b0;
    end else begin
      cfg_reg  <= cfg_next;
      lock_reg <= lock_next;
      trig_reg <= trig_next;
      dma_reg  <= dma_next;
      flag_reg <= flag_next;
      pin_reg  <= pin;
    end
  end

  // open drain only reaches the pad while a capable function drives it
  always_comb begin
    cfg            = cfg_reg;
    cfg.open_drain = cfg_reg.open_drain & od_func;
  end

  assign irq_req = flag_reg & ~dma_reg;
  assign dma_req = flag_reg & dma_reg;

  always_comb begin
    rdata                     = '0;
    rdata[F_PULL_SEL]         = cfg_reg.pull_sel;
    rdata[F_PULL_EN]          = cfg_reg.pull_en;
    rdata[F_FILT]             = cfg_reg.filter_en;
    rdata[F_OD]               = cfg_reg.open_drain;
    rdata[F_HD]               = cfg_reg.high_drive;
    rdata[F_MUX +: MUX_W]     = cfg_reg.mux;
    rdata[F_LOCK]             = lock_reg;
    rdata[F_TRIG +: 2]        = trig_reg;
    rdata[F_DMA]              = dma_reg;
    rdata[F_FLAG]             = flag_reg;
  end

endmodule

// [design/pad_ctrl_top.sv]
// top of the port pad control block: pads, nmi, watchdog polarity, registers
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
module pad_ctrl_top
  import pad_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  // register port
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  // pads
  input  wire logic [PAD_COUNT-1:0] PAD_IN,
  input  wire logic [PAD_COUNT-1:0] OD_FUNC_SEL,
  output pad_ctrl_s                 PAD_CTRL [PAD_COUNT],
  // requests
  output logic [PORT_COUNT-1:0] PORT_IRQ,
  output logic [PORT_COUNT-1:0] PORT_DMA_REQ,
  output logic                  NMI_REQ,
  output logic                  IRQ,
  // watchdog monitor
  input  wire logic             WATCHDOG_MONITOR_SAFETY_IN,
  output logic                  WATCHDOG_MONITOR_SAFETY_ASSERTED
);

  // ****************************************
  // pad cells
  // ****************************************
  logic [DATA_W-1:0]    pad_rd [PAD_COUNT];
  logic [PAD_COUNT-1:0] irq_v;
  logic [PAD_COUNT-1:0] dma_v;
  logic [PAD_COUNT-1:0] pull_sel_v;
  logic [PAD_COUNT-1:0] pull_en_v;
  logic [PAD_COUNT-1:0] filt_v;
  logic [PAD_COUNT-1:0] od_v;
  logic [PAD_COUNT-1:0] hd_v;
  logic [PAD_COUNT-1:0] mux7_v;
  logic [PAD_COUNT-1:0] mux0_v;

  genvar gi;
  generate
    for (gi = 0; gi < PAD_COUNT; gi++) begin : g_pad
      logic pad_wr;
      assign pad_wr = WR & (ADDR == ADDR_W'(gi));
      pad_ctrl_cell #(
        .EXISTS       (PAD_EXISTS[gi]),
        .PULL_SEL_RST (PULL_SEL_DEF[gi]),
        .PULL_EN_RST  (PULL_EN_DEF[gi]),
        .FILT_CAP_P   (FILT_CAP[gi]),
        .FILT_RST     (FILT_DEF[gi]),
        .HD_CAP_P     (HD_CAP[gi]),
        .MUX_RST      (MUX7_DEF[gi] ? MUX_ALT_SEVEN : MUX_ALT_ZERO)
      ) u_cell (
        .clk     (CLK),
        .reset_n (RESET_N),
        .wr_en   (pad_wr),
        .wdata   (WDATA),
        .rdata   (pad_rd[gi]),
        .pin     (PAD_IN[gi]),
        .od_func (OD_FUNC_SEL[gi]),
        .cfg     (PAD_CTRL[gi]),
        .irq_req (irq_v[gi]),
        .dma_req (dma_v[gi])
      );
      assign pull_sel_v[gi] = PAD_CTRL[gi].pull_sel;
      assign pull_en_v[gi]  = PAD_CTRL[gi].pull_en;
      assign filt_v[gi]     = PAD_CTRL[gi].filter_en;
      assign od_v[gi]       = PAD_CTRL[gi].open_drain;
      assign hd_v[gi]       = PAD_CTRL[gi].high_drive;
      assign mux7_v[gi]     = PAD_CTRL[gi].mux == MUX_ALT_SEVEN;
      assign mux0_v[gi]     = PAD_CTRL[gi].mux == MUX_ALT_ZERO;
    end
  endgenerate

  // ****************************************
  // port request summary
  // ****************************************
  logic [PORT_COUNT-1:0] port_irq_next;
  logic [PORT_COUNT-1:0] port_dma_next;
  logic [PORT_COUNT-1:0] port_irq_reg;
  logic [PORT_COUNT-1:0] port_dma_reg;

  genvar gp;
  generate
    for (gp = 0; gp < PORT_COUNT; gp++) begin : g_port
      assign port_irq_next[gp] = |irq_v[gp*PADS_PER_PORT +: PADS_PER_PORT];
      assign port_dma_next[gp] = |dma_v[gp*PADS_PER_PORT +: PADS_PER_PORT];
    end
  endgenerate

  // ****************************************
  // nmi pad and watchdog monitor input
  // ****************************************
  logic nmi_req_reg;
  logic nmi_req_next;
  logic wdog_pol_reg;
  logic wdog_pol_next;
  logic wdog_asrt_reg;
  logic wdog_asrt_next;
  logic wdog_ctrl_wr;

  // pad is active low only while its nmi function is selected
  assign nmi_req_next = (PAD_CTRL[NMI_PAD].mux == MUX_ALT_SEVEN) & ~PAD_IN[NMI_PAD];

  assign wdog_ctrl_wr   = WR & (ADDR == WDOG_CTRL_ADDR);
  assign wdog_pol_next  = wdog_ctrl_wr ? WDATA[F_ASSERT_POL] : wdog_pol_reg;
  assign wdog_asrt_next = ~(WATCHDOG_MONITOR_SAFETY_IN ^ wdog_pol_reg);

  // ****************************************
  // status, mask and interrupt
  // ****************************************
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask_reg;
  logic [ST_W-1:0] mask_next;
  logic            status_wr;
  logic            nmi_evt;
  logic            wdog_evt;

  assign status_wr = WR & (ADDR == STATUS_ADDR);
  assign nmi_evt   = nmi_req_next & ~nmi_req_reg;
  assign wdog_evt  = wdog_asrt_next & ~wdog_asrt_reg;
  assign mask_next = (WR & (ADDR == MASK_ADDR)) ? WDATA[ST_W-1:0] : mask_reg;

  event_flag u_nmi_flag (
    .clk     (CLK),
    .reset_n (RESET_N),
    .set     (nmi_evt),
    .clr     (status_wr & WDATA[ST_NMI]),
    .q       (status[ST_NMI])
  );

  event_flag u_wdog_flag (
    .clk     (CLK),
    .reset_n (RESET_N),
    .set     (wdog_evt),
    .clr     (status_wr & WDATA[ST_WDOG]),
    .q       (status[ST_WDOG])
  );

  // port bits follow the pad flags; clear them at the pads
  assign status[ST_PORT +: PORT_COUNT] = port_irq_reg | port_dma_reg;
  assign IRQ = |(status & mask_reg);

  // ****************************************
  // read path
  // ****************************************
  logic [DATA_W-1:0] rd_sel;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  assign rd_sel = (ADDR < PAD_LIMIT)         ? pad_rd[ADDR[6:0]] :
                  (ADDR == STATUS_ADDR)      ? DATA_W'(status) :
                  (ADDR == MASK_ADDR)        ? DATA_W'(mask_reg) :
                  (ADDR == WDOG_CTRL_ADDR)   ? (DATA_W'(wdog_pol_reg) << F_ASSERT_POL) :
                                               '0;
  // data stand for one cycle only, zero otherwise
  assign rdata_next = RD ? rd_sel : '0;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      port_irq_reg  <= '0;
      port_dma_reg  <= '0;
      nmi_req_reg   <= 1'b0;
      wdog_pol_reg  <= POL_RST;
      wdog_asrt_reg <= 1'b0;
      mask_reg      <= '0;
      rdata_reg     <= '0;
    end else begin
      port_irq_reg  <= port_irq_next;
      port_dma_reg  <= port_dma_next;
      nmi_req_reg   <= nmi_req_next;
      wdog_pol_reg  <= wdog_pol_next;
      wdog_asrt_reg <= wdog_asrt_next;
      mask_reg      <= mask_next;
      rdata_reg     <= rdata_next;
    end
  end

  assign RDATA                            = rdata_reg;
  assign PORT_IRQ                         = port_irq_reg;
  assign PORT_DMA_REQ                     = port_dma_reg;
  assign NMI_REQ                          = nmi_req_reg;
  assign WATCHDOG_MONITOR_SAFETY_ASSERTED = wdog_asrt_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  property p_pull_sel_rst;
    $rose(RESET_N) |-> (pull_sel_v == PULL_SEL_DEF);
  endproperty
  a_pull_sel_rst: assert property (p_pull_sel_rst) else $error("pull select reset value wrong");

  property p_pull_en_rst;
    $rose(RESET_N) |-> (pull_en_v == PULL_EN_DEF) && (pull_sel_v[DEBUG_CLOCK_PAD] == 1'b0);
  endproperty
  a_pull_en_rst: assert property (p_pull_en_rst) else $error("pull enable reset value wrong");

  property p_filt_cap;
    (filt_v & ~FILT_CAP) == '0;
  endproperty
  a_filt_cap: assert property (p_filt_cap) else $error("filter set on pad without control");

  property p_filt_rst;
    $rose(RESET_N) |-> (filt_v == FILT_DEF);
  endproperty
  a_filt_rst: assert property (p_filt_rst) else $error("filter reset value wrong");

  property p_od_func;
    (od_v & ~OD_FUNC_SEL) == '0;
  endproperty
  a_od_func: assert property (p_od_func) else $error("open drain on incapable function");

  property p_od_rst;
    $rose(RESET_N) |-> (od_v == '0);
  endproperty
  a_od_rst: assert property (p_od_rst) else $error("open drain not off after reset");

  property p_hd_cap;
    (hd_v & ~HD_CAP) == '0;
  endproperty
  a_hd_cap: assert property (p_hd_cap) else $error("high drive set on pad without control");

  property p_hd_rst;
    $rose(RESET_N) |-> (hd_v == '0);
  endproperty
  a_hd_rst: assert property (p_hd_rst) else $error("high drive not off after reset");

  property p_lock_hold;
    (pad_rd[13][F_LOCK] && WR && ADDR == 8'h0d) |=> $stable(pull_en_v[13]) && $stable(pull_sel_v[13])
                                                    && $stable(mux7_v[13]);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked pad changed");

  property p_port_irq;
    irq_v[PADS_PER_PORT] |=> PORT_IRQ[1];
  endproperty
  a_port_irq: assert property (p_port_irq) else $error("port interrupt not raised");

  property p_nmi;
    $past(RESET_N) |-> (NMI_REQ == ($past(mux7_v[NMI_PAD]) && !$past(PAD_IN[NMI_PAD])));
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi request does not follow pad");

  property p_wdog_pol;
    $past(RESET_N) |-> (WATCHDOG_MONITOR_SAFETY_ASSERTED
                        == ($past(WATCHDOG_MONITOR_SAFETY_IN) == $past(wdog_pol_reg)));
  endproperty
  a_wdog_pol: assert property (p_wdog_pol) else $error("safety input polarity wrong");

  property p_mux_rst;
    $rose(RESET_N) |-> (mux7_v == MUX7_DEF) && (mux0_v == ~MUX7_DEF);
  endproperty
  a_mux_rst: assert property (p_mux_rst) else $error("mux reset value wrong");

endmodule

// [tb/pad_world.sv]
// model of the circuitry outside the pads: drivers, pull resistors, floating pins
`timescale 1ns/1ps
module pad_world
  import pad_ctrl_pkg::*;
(
  // clock
  input  wire logic                 clk,
  // bench commands
  input  wire logic [PAD_COUNT-1:0] drv_en,
  input  wire logic [PAD_COUNT-1:0] drv_val,
  // device side
  input  pad_ctrl_s                 ctrl [PAD_COUNT],
  output logic      [PAD_COUNT-1:0] pad_in
);
  // ****************************************
  // pad levels
  // ****************************************
  initial pad_in = '0;
  // a pin with no driver and no pull floats: toggle so no stale level is trusted
  always @(posedge clk) begin
    for (int k = 0; k < PAD_COUNT; k++) begin
      if (drv_en[k]) begin
        pad_in[k] <= drv_val[k];
      end else if (ctrl[k].pull_en) begin
        pad_in[k] <= ctrl[k].pull_sel;
      end else begin
        pad_in[k] <= ~pad_in[k];
      end
    end
  end
endmodule

// [tb/test_port_pad_control_defaults.sv]
// self-checking bench of the port pad control block
`timescale 1ns/1ps
module test_port_pad_control_defaults
  import pad_ctrl_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic                  clk;
  logic                  reset_n;
  logic [ADDR_W-1:0]     addr;
  logic [DATA_W-1:0]     wdata;
  logic                  wr_s;
  logic                  rd_s;
  logic [DATA_W-1:0]     rdata;
  logic [PAD_COUNT-1:0]  pad_in;
  logic [PAD_COUNT-1:0]  od_sel;
  pad_ctrl_s             pad_ctrl [PAD_COUNT];
  logic [PORT_COUNT-1:0] port_irq;
  logic [PORT_COUNT-1:0] port_dma;
  logic                  nmi_req;
  logic                  irq;
  logic                  safe_in;
  logic                  safe_asserted;
  logic [PAD_COUNT-1:0]  drv_en;
  logic [PAD_COUNT-1:0]  drv_val;
  int                    num_errors;
  int                    n_tests;

  typedef struct {
    int          pad;
    logic [31:0] d;
    logic        od;
    pad_ctrl_s   e;
  } row_s;

  // cfg layout is {mux, high_drive, open_drain, filter_en, pull_en, pull_sel}
  row_s rows [12] = '{
    '{10, 32'h4, 1'b0, 8'h00},
    '{57, 32'h707, 1'b0, 8'he7},
    '{22, 32'h10, 1'b0, 8'h10},
    '{70, 32'h10, 1'b0, 8'h10},
    '{73, 32'h10, 1'b0, 8'h10},
    '{0, 32'h10, 1'b0, 8'h00},
    '{36, 32'h10, 1'b0, 8'h00},
    '{71, 32'h10, 1'b0, 8'h00},
    '{74, 32'h10, 1'b0, 8'h00},
    '{30, 32'h8, 1'b1, 8'h08},
    '{31, 32'h8, 1'b0, 8'h00},
    '{12, 32'h303, 1'b0, 8'h63}
  };

  pad_ctrl_top i_pad_ctrl_top (
    .CLK                              (clk),
    .RESET_N                          (reset_n),
    .ADDR                             (addr),
    .WDATA                            (wdata),
    .WR                               (wr_s),
    .RD                               (rd_s),
    .RDATA                            (rdata),
    .PAD_IN                           (pad_in),
    .OD_FUNC_SEL                      (od_sel),
    .PAD_CTRL                         (pad_ctrl),
    .PORT_IRQ                         (port_irq),
    .PORT_DMA_REQ                     (port_dma),
    .NMI_REQ                          (nmi_req),
    .IRQ                              (irq),
    .WATCHDOG_MONITOR_SAFETY_IN       (safe_in),
    .WATCHDOG_MONITOR_SAFETY_ASSERTED (safe_asserted)
  );

  pad_world i_pad_world (
    .clk     (clk),
    .drv_en  (drv_en),
    .drv_val (drv_val),
    .ctrl    (pad_ctrl),
    .pad_in  (pad_in)
  );

  always #25 clk = ~clk;

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 check(what, exp, rdata);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check_defaults();
    pad_ctrl_s e;
    for (int k = 0; k < PAD_COUNT; k++) begin
      e = '0;
      e.pull_sel = (k == DEBUG_DATA_PAD || k == RESET_PAD || k == NMI_PAD);
      e.pull_en = e.pull_sel || (k == DEBUG_CLOCK_PAD);
      e.filter_en = (k == RESET_PAD);
      e.mux = e.pull_en ? MUX_ALT_SEVEN : MUX_ALT_ZERO;
      check($sformatf("pad %0d default", k), 32'(e), 32'(pad_ctrl[k]));
    end
    check("nmi request", 32'h0, 32'(nmi_req));
    check("port requests", 32'h0, 32'(port_irq | port_dma));
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    int   k;
    logic dma;
    clk = 1'b0;
    reset_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    od_sel = '0;
    safe_in = 1'b1;
    num_errors = 0;
    n_tests = 0;
    drv_val = '0;
    drv_en = '1;
    drv_en[DEBUG_DATA_PAD] = 1'b0;
    drv_en[RESET_PAD] = 1'b0;
    drv_en[DEBUG_CLOCK_PAD] = 1'b0;
    drv_en[NMI_PAD] = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    #1 check_defaults();
    rd("reset pad reg", 8'(RESET_PAD), 32'h707);
    wait_n(1);
    check("read data after one cycle", 32'h0, rdata);
    rd("unmapped read", 8'h70, 32'h0);
    $display("test defaults done");
    foreach (rows[i]) begin
      @(posedge clk);
      od_sel <= {PAD_COUNT{rows[i].od}};
      wr(8'(rows[i].pad), rows[i].d);
      check($sformatf("pad %0d cfg", rows[i].pad), 32'(rows[i].e), 32'(pad_ctrl[rows[i].pad]));
    end
    $display("test table done");
    // lock holds config until reset, so this pad stays as first written
    wr(8'd13, 32'h8001);
    wr(8'd13, 32'h0702);
    check("locked pad cfg", 32'h01, 32'(pad_ctrl[13]));
    $display("test lock done");
    for (int p = 0; p < PORT_COUNT; p++) begin
      k = p * 18 + 1;
      dma = p[0];
      wr(8'(k), {13'h0, dma, 2'h1, 16'h0});
      @(posedge clk);
      drv_val[k] <= 1'b1;
      wr(MASK_ADDR, 32'h1 << (ST_PORT + p));
      wait_n(3);
      check("irq line", dma ? 32'h0 : 32'(1 << p), 32'(port_irq));
      check("dma line", dma ? 32'(1 << p) : 32'h0, 32'(port_dma));
      check("summary irq", 32'h1, 32'(irq));
      wr(8'(k), {7'h0, 1'b1, 5'h0, dma, 2'h1, 16'h0});
      wait_n(2);
      check("requests cleared", 32'h0, 32'(port_irq | port_dma | irq));
    end
    // falling trigger: a rise must be ignored, the fall must flag
    wr(8'd2, 32'h20000);
    @(posedge clk);
    drv_val[2] <= 1'b1;
    wait_n(3);
    check("no event on rise", 32'h0, 32'(port_irq));
    @(posedge clk);
    drv_val[2] <= 1'b0;
    wait_n(3);
    check("fall event", 32'h1, 32'(port_irq));
    wr(8'd2, 32'h1000000);
    $display("test pin events done");
    @(posedge clk);
    drv_en[NMI_PAD] <= 1'b1;
    drv_val[NMI_PAD] <= 1'b0;
    wait_n(3);
    check("nmi forced", 32'h1, 32'(nmi_req));
    rd("status nmi", STATUS_ADDR, 32'h1);
    wr(MASK_ADDR, 32'h1);
    check("irq on nmi", 32'h1, 32'(irq));
    wr(STATUS_ADDR, 32'h1);
    check("irq cleared", 32'h0, 32'(irq));
    @(posedge clk);
    drv_val[NMI_PAD] <= 1'b1;
    wr(8'(NMI_PAD), 32'h0);
    @(posedge clk);
    drv_val[NMI_PAD] <= 1'b0;
    wait_n(3);
    check("nmi with other function", 32'h0, 32'(nmi_req));
    $display("test nmi done");
    @(posedge clk);
    safe_in <= 1'b0;
    wait_n(2);
    check("safety active low", 32'h1, 32'(safe_asserted));
    wr(WDOG_CTRL_ADDR, 32'h1);
    wait_n(2);
    check("safety low inverted", 32'h0, 32'(safe_asserted));
    @(posedge clk);
    safe_in <= 1'b1;
    wait_n(2);
    check("safety active high", 32'h1, 32'(safe_asserted));
    rd("status safety event", STATUS_ADDR, 32'h2);
    rd("mask readback", MASK_ADDR, 32'h1);
    $display("test safety polarity done");
    // second reset: locked pad and polarity must return to defaults
    @(posedge clk);
    drv_val[NMI_PAD] <= 1'b1;
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    #1 check_defaults();
    rd("polarity after reset", WDOG_CTRL_ADDR, 32'h0);
    $display("test second reset done");
    end_of_test();
  end

  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule
